//--- rtl/buck_ctl_pkg.sv
// package: register map, field layout and reset values of the buck sleep and scaling control
package buck_ctl_pkg;
    localparam logic [15:0] SLEEP_CTRL_INDEX = 16'h4059;
    localparam logic [15:0] SCALING_CTRL_INDEX = 16'h405A;
    localparam logic [15:0] STATUS_INDEX = 16'h4060;
    localparam int ADDR_W = 20;
    localparam int SLOT_HI = 15;
    localparam int SLOT_LO = 13;
    localparam int MODE_HI = 9;
    localparam int MODE_LO = 8;
    localparam int VSEL_HI = 6;
    localparam int VSEL_LO = 0;
    localparam int SRC_HI = 12;
    localparam int SRC_LO = 11;
    localparam logic [2:0] SLOT_RESET = 3'h0;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [6:0] VSEL_RESET = 7'h00;
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [2:0] SLOT_SLEEP_TS5 = 3'h0;
    localparam logic [2:0] SLOT_SLEEP_TS3 = 3'h6;
    localparam logic [2:0] SLOT_SLEEP_TS1 = 3'h7;
    localparam logic [2:0] SLOT_DISABLE_FIRST = 3'h1;
    localparam logic [2:0] SLOT_DISABLE_LAST = 3'h5;
    localparam logic [2:0] TS1 = 3'h1;
    localparam logic [2:0] TS3 = 3'h3;
    localparam logic [2:0] TS5 = 3'h5;
    localparam logic [2:0] TS_AFTER_LAST = 3'h6;
    localparam logic [1:0] CONDUCT_FORCED_CONT = 2'h0;
    localparam logic [1:0] CONDUCT_AUTO_SKIP = 2'h1;
    localparam logic [1:0] CONDUCT_LINEAR = 2'h2;
    localparam logic [1:0] CONDUCT_HYSTERETIC = 2'h3;
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_REGISTER = 2'h1;
    localparam logic [1:0] SRC_HW_A = 2'h2;
    localparam logic [1:0] SRC_HW_B = 2'h3;
    localparam logic [6:0] VSEL_FLOOR_CODE = 7'h08;
    localparam logic [6:0] VSEL_CEIL_CODE = 7'h68;
    localparam logic [6:0] VSEL_4MHZ_MAX = 7'h48;
    localparam logic [14:0] V_FLOOR_TENTH_MV = 15'h1770;
    localparam logic [7:0] V_STEP_TENTH_MV = 8'h7D;
endpackage : buck_ctl_pkg

//--- rtl/buck_sleep_dvs_control.sv
// buck1 sleep slot, sleep mode/voltage and dynamic voltage scaling control with apb registers
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE_01 - slot resets to 000; 000 sleeps in slot 5, 110 in slot 3, 111 in slot 1.
// RULE_02 - slot codes 001 to 101 disable in slot 5 down to slot 1, one slot earlier per code.
// RULE_03 - under a hardware enable input, codes 001 to 101 pick the sleep slot instead.
// RULE_04 - sleep mode: 00 forced continuous, 01 auto skip, 10 linear, 11 hysteretic; reset 11.
// RULE_05 - sleep voltage code, reset 0: 12.5 mV steps, 0.6 V up to 08h, 1.8 V from 68h.
// RULE_06 - software keeps every voltage code at or below 48h while switching at 4 MHz.
// RULE_07 - scaling source, reset 00: off, register, hardware input a or hardware input b.
// RULE_08 - the scaling voltage code, reset zero, maps like the sleep voltage code with clamping.
// RULE_09 - while scaling is active the target is the scaling code, otherwise the normal code; once sleep is entered the code targets the sleep code instead.
module buck_sleep_dvs_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [buck_ctl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_request,
    input wire logic timeslot_strobe,
    input wire logic [2:0] timeslot_number,
    input wire logic hw_enable_assigned,
    input wire logic switching_4mhz,
    input wire logic [6:0] normal_voltage_code,
    input wire logic [1:0] normal_conduction_mode,
    input wire logic hw_scaling_input_a,
    input wire logic hw_scaling_input_b,
    output logic converter_enable,
    output logic sleep_active,
    output logic scaling_active,
    output logic [1:0] conduction_mode,
    output logic [6:0] target_voltage_code,
    output logic [14:0] target_voltage_tenth_mv,
    output logic code_limit_violation
);
    typedef struct packed {
        logic [2:0] buck1_sleep_timeslot;
        logic [1:0] buck1_sleep_conduction_mode;
        logic [6:0] buck1_sleep_voltage_code;
        logic [1:0] buck1_scaling_source;
        logic [6:0] buck1_scaling_voltage_code;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic hw_a;
        logic hw_b;
        logic sleep_entered;
        logic disabled;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic converter_enable;
        logic scaling_active;
        logic [1:0] conduction_mode;
        logic [6:0] target_code;
        logic [14:0] target_mv;
        logic limit_violation;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [14:0] decoded_mv;
    logic [6:0] next_code;
    logic access;
    logic commit;
    logic [buck_ctl_pkg::ADDR_W-1:0] a_sleep;
    logic [buck_ctl_pkg::ADDR_W-1:0] a_scale;
    logic [buck_ctl_pkg::ADDR_W-1:0] a_stat;
    logic [2:0] slot;
    logic [2:0] action_ts;
    logic disable_code;
    logic scale_on;

    assign a_sleep = buck_ctl_pkg::ADDR_W'({buck_ctl_pkg::SLEEP_CTRL_INDEX, 2'b00});
    assign a_scale = buck_ctl_pkg::ADDR_W'({buck_ctl_pkg::SCALING_CTRL_INDEX, 2'b00});
    assign a_stat = buck_ctl_pkg::ADDR_W'({buck_ctl_pkg::STATUS_INDEX, 2'b00});

    buck_voltage_decode u_decode (
        .code(next_code),
        .tenth_mv(decoded_mv)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        slot = st_r.buck1_sleep_timeslot;
        // pins: three stages, a change counts once the last two agree
        st_nxt.sync_a = {st_r.sync_a[1:0], hw_scaling_input_a};
        st_nxt.sync_b = {st_r.sync_b[1:0], hw_scaling_input_b};
        if (st_r.sync_a[2] == st_r.sync_a[1]) begin
            st_nxt.hw_a = st_r.sync_a[2];
        end
        if (st_r.sync_b[2] == st_r.sync_b[1]) begin
            st_nxt.hw_b = st_r.sync_b[2];
        end
        // apb: one wait state, answer on the second access cycle
        access = psel && penable && !st_r.pready;
        st_nxt.pready = access;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = 32'h0000_0000;
        if (access) begin
            if (paddr == a_sleep) begin
                st_nxt.prdata[buck_ctl_pkg::SLOT_HI:buck_ctl_pkg::SLOT_LO] = slot;
                st_nxt.prdata[buck_ctl_pkg::MODE_HI:buck_ctl_pkg::MODE_LO] =
                    st_r.buck1_sleep_conduction_mode;
                st_nxt.prdata[buck_ctl_pkg::VSEL_HI:buck_ctl_pkg::VSEL_LO] =
                    st_r.buck1_sleep_voltage_code;
            end else if (paddr == a_scale) begin
                st_nxt.prdata[buck_ctl_pkg::SRC_HI:buck_ctl_pkg::SRC_LO] =
                    st_r.buck1_scaling_source;
                st_nxt.prdata[buck_ctl_pkg::VSEL_HI:buck_ctl_pkg::VSEL_LO] =
                    st_r.buck1_scaling_voltage_code;
            end else if (paddr == a_stat && !pwrite) begin
                st_nxt.prdata[0] = st_r.sleep_entered;
                st_nxt.prdata[1] = st_r.disabled;
                st_nxt.prdata[2] = st_r.scaling_active;
                st_nxt.prdata[3] = st_r.limit_violation;
                st_nxt.prdata[10:4] = st_r.target_code;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
        // writes land only at the edge where the master samples pready high
        commit = psel && penable && pwrite && st_r.pready;
        if (commit && paddr == a_sleep) begin
            st_nxt.buck1_sleep_timeslot = pwdata[buck_ctl_pkg::SLOT_HI:buck_ctl_pkg::SLOT_LO];
            st_nxt.buck1_sleep_conduction_mode =
                pwdata[buck_ctl_pkg::MODE_HI:buck_ctl_pkg::MODE_LO]; // RULE_04
            st_nxt.buck1_sleep_voltage_code =
                pwdata[buck_ctl_pkg::VSEL_HI:buck_ctl_pkg::VSEL_LO];
        end
        if (commit && paddr == a_scale) begin
            st_nxt.buck1_scaling_source =
                pwdata[buck_ctl_pkg::SRC_HI:buck_ctl_pkg::SRC_LO]; // RULE_07
            st_nxt.buck1_scaling_voltage_code =
                pwdata[buck_ctl_pkg::VSEL_HI:buck_ctl_pkg::VSEL_LO]; // RULE_08
        end
        ////////////////////////////////////////////////////////////////////////////////
        // sleep slot decode
        disable_code = (slot >= buck_ctl_pkg::SLOT_DISABLE_FIRST) &&
                       (slot <= buck_ctl_pkg::SLOT_DISABLE_LAST);
        case (slot)
            buck_ctl_pkg::SLOT_SLEEP_TS5: action_ts = buck_ctl_pkg::TS5; // RULE_01
            buck_ctl_pkg::SLOT_SLEEP_TS3: action_ts = buck_ctl_pkg::TS3; // RULE_01
            buck_ctl_pkg::SLOT_SLEEP_TS1: action_ts = buck_ctl_pkg::TS1; // RULE_01
            default: action_ts = buck_ctl_pkg::TS_AFTER_LAST - slot; // RULE_02
        endcase
        if (!sleep_request) begin
            st_nxt.sleep_entered = 1'b0;
            st_nxt.disabled = 1'b0;
        end else if (timeslot_strobe && timeslot_number == action_ts) begin
            if (disable_code && !hw_enable_assigned) begin
                st_nxt.disabled = 1'b1; // RULE_02
            end else begin
                st_nxt.sleep_entered = 1'b1; // RULE_03
            end
        end
        ////////////////////////////////////////////////////////////////////////////////
        // scaling source and target selection
        case (st_r.buck1_scaling_source)
            buck_ctl_pkg::SRC_REGISTER: scale_on = 1'b1; // RULE_07
            buck_ctl_pkg::SRC_HW_A: scale_on = st_r.hw_a; // RULE_07
            buck_ctl_pkg::SRC_HW_B: scale_on = st_r.hw_b; // RULE_07
            default: scale_on = 1'b0;
        endcase
        // sleep settings override scaling once sleep is entered
        if (st_nxt.sleep_entered) begin
            next_code = st_r.buck1_sleep_voltage_code; // RULE_05
            st_nxt.conduction_mode = st_r.buck1_sleep_conduction_mode; // RULE_04
        end else if (scale_on) begin
            next_code = st_r.buck1_scaling_voltage_code; // RULE_09
            st_nxt.conduction_mode = normal_conduction_mode;
        end else begin
            next_code = normal_voltage_code; // RULE_09
            st_nxt.conduction_mode = normal_conduction_mode;
        end
        st_nxt.scaling_active = scale_on;
        st_nxt.target_code = next_code;
        st_nxt.target_mv = decoded_mv; // RULE_05
        st_nxt.converter_enable = !st_nxt.disabled;
        // flags an out-of-range code; the converter itself is not protected by it
        st_nxt.limit_violation = switching_4mhz &&
            (next_code > buck_ctl_pkg::VSEL_4MHZ_MAX); // RULE_06
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.buck1_sleep_timeslot <= buck_ctl_pkg::SLOT_RESET; // RULE_01
            st_r.buck1_sleep_conduction_mode <= buck_ctl_pkg::MODE_RESET; // RULE_04
            st_r.buck1_sleep_voltage_code <= buck_ctl_pkg::VSEL_RESET; // RULE_05
            st_r.buck1_scaling_source <= buck_ctl_pkg::SRC_RESET; // RULE_07
            st_r.buck1_scaling_voltage_code <= buck_ctl_pkg::VSEL_RESET; // RULE_08
            st_r.converter_enable <= 1'b1;
            st_r.target_mv <= buck_ctl_pkg::V_FLOOR_TENTH_MV;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign converter_enable = st_r.converter_enable;
    assign sleep_active = st_r.sleep_entered;
    assign scaling_active = st_r.scaling_active;
    assign conduction_mode = st_r.conduction_mode;
    assign target_voltage_code = st_r.target_code;
    assign target_voltage_tenth_mv = st_r.target_mv;
    assign code_limit_violation = st_r.limit_violation;
endmodule : buck_sleep_dvs_control
`default_nettype wire

//--- rtl/buck_voltage_decode.sv
// code-to-voltage mapping in units of 0.1 mV, clamped at both ends
`timescale 1ns/10ps
`default_nettype none
module buck_voltage_decode (
    input wire logic [6:0] code,
    output logic [14:0] tenth_mv
);
    logic [6:0] clamped;
    logic [6:0] steps;
    logic [14:0] product;
    always_comb begin
        if (code < buck_ctl_pkg::VSEL_FLOOR_CODE) begin
            clamped = buck_ctl_pkg::VSEL_FLOOR_CODE;
        end else if (code > buck_ctl_pkg::VSEL_CEIL_CODE) begin
            clamped = buck_ctl_pkg::VSEL_CEIL_CODE;
        end else begin
            clamped = code;
        end
        steps = clamped - buck_ctl_pkg::VSEL_FLOOR_CODE;
        // widen both factors first so the product cannot wrap at eight bits
        product = 15'(steps) * 15'(buck_ctl_pkg::V_STEP_TENTH_MV);
        tenth_mv = buck_ctl_pkg::V_FLOOR_TENTH_MV + product;
    end
endmodule : buck_voltage_decode
`default_nettype wire

//--- verif/buck_ctl_assertions.sv
// checker: port-level properties of the buck sleep and scaling control
`timescale 1ns/10ps
`default_nettype none
module buck_ctl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_request,
    input wire logic timeslot_strobe,
    input wire logic hw_enable_assigned,
    input wire logic [6:0] normal_voltage_code,
    input wire logic [1:0] normal_conduction_mode,
    input wire logic converter_enable,
    input wire logic sleep_active,
    input wire logic scaling_active,
    input wire logic [1:0] conduction_mode,
    input wire logic [6:0] target_voltage_code,
    input wire logic [14:0] target_voltage_tenth_mv
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // clamp at both ends, in units of 0.1 mV
    function automatic logic [14:0] mv(input logic [6:0] c);
        return (c < 7'h08) ? 15'h1770 : (c > 7'h68) ? 15'h4650 : 15'(6000 + 125 * (int'(c) - 8));
    endfunction : mv
    // two idle cycles, so the lagging target has caught up with the normal inputs
    sequence s_idle;
        !sleep_active && !scaling_active ##1 !sleep_active && !scaling_active;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    property p_entry; $rose(sleep_active) |-> $past(sleep_request && timeslot_strobe); endproperty
    a_entry: assert property (p_entry) else $error("sleep entered without a slot");
    property p_hold; sleep_active && sleep_request |=> sleep_active; endproperty
    a_hold: assert property (p_hold) else $error("sleep state dropped early");
    property p_off;
        $fell(converter_enable) |-> $past(sleep_request && timeslot_strobe);
    endproperty
    a_off: assert property (p_off) else $error("disable without a slot");
    property p_off_hold; !converter_enable && sleep_request |=> !converter_enable; endproperty
    a_off_hold: assert property (p_off_hold) else $error("disable not held");
    property p_release; !sleep_request |=> converter_enable && !sleep_active; endproperty
    a_release: assert property (p_release) else $error("sleep not cleared");
    property p_hw; $fell(converter_enable) |-> !$past(hw_enable_assigned); endproperty
    a_hw: assert property (p_hw) else $error("disabled under hardware enable");
    property p_mv;
        $stable(target_voltage_code) |-> target_voltage_tenth_mv == mv(target_voltage_code);
    endproperty
    a_mv: assert property (p_mv) else $error("voltage decode wrong");
    property p_normal;
        s_idle |-> target_voltage_code == $past(normal_voltage_code)
            && conduction_mode == $past(normal_conduction_mode);
    endproperty
    a_normal: assert property (p_normal) else $error("normal settings not followed");
endmodule : buck_ctl_checker
bind buck_sleep_dvs_control buck_ctl_checker buck_ctl_checker_i (
    .pclk(pclk), .presetn(presetn), .sleep_request(sleep_request),
    .timeslot_strobe(timeslot_strobe), .hw_enable_assigned(hw_enable_assigned),
    .normal_voltage_code(normal_voltage_code), .normal_conduction_mode(normal_conduction_mode),
    .converter_enable(converter_enable), .sleep_active(sleep_active),
    .scaling_active(scaling_active), .conduction_mode(conduction_mode),
    .target_voltage_code(target_voltage_code), .target_voltage_tenth_mv(target_voltage_tenth_mv)
);
`default_nettype wire

//--- verif/tb_top.sv
// testbench: register access, scaling selection and sleep sequencing of the buck control
`timescale 1ns/10ps
`default_nettype none
`define chk(a, x) begin samples_checked++; if ((a) !== (x)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, x); end end
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [19:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, en, slp, scl, viol, e, dis;
    logic slp_req = 0, strobe = 0, hw_en = 0, sw4 = 0, pa = 0, pb = 0;
    logic [2:0] ts = 3'h1;
    logic [6:0] nv = '0, tc;
    logic [1:0] nm = '0, cm;
    logic [14:0] tmv;
    int n_fail = 0, samples_checked = 0, r, sm, vv, sc, act;
    always #10 pclk = ~pclk;
    buck_sleep_dvs_control buck_sleep_dvs_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_request(slp_req), .timeslot_strobe(strobe), .timeslot_number(ts),
        .hw_enable_assigned(hw_en), .switching_4mhz(sw4), .normal_voltage_code(nv),
        .normal_conduction_mode(nm), .hw_scaling_input_a(pa), .hw_scaling_input_b(pb),
        .converter_enable(en), .sleep_active(slp), .scaling_active(scl), .conduction_mode(cm),
        .target_voltage_code(tc), .target_voltage_tenth_mv(tmv), .code_limit_violation(viol)
    );
    function automatic int mv(input int c);
        return c < 8 ? 6000 : c > 104 ? 18000 : 6000 + 125 * (c - 8);
    endfunction : mv
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // settle covers the 3-stage pin synchroniser plus the output register
    task automatic outs(input logic x_en, input logic x_slp, input logic x_scl, input int v, m);
        repeat (6) @(posedge pclk);
        `chk(en, x_en)
        `chk(slp, x_slp)
        `chk(scl, x_scl)
        `chk(tc, 7'(v))
        `chk(cm, 2'(m))
        `chk(tmv, 15'(mv(v)))
        `chk(viol, 1'(sw4 && v > 72))
    endtask : outs
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'hF764859D);
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(0, 20'h10164, 0);
        `chk(q, 32'h300)
        `chk(e, 1'h0)
        apb(0, 20'h10168, 0);
        `chk(q, 32'h0)
        apb(1, 20'h10170, 32'hFFFF);
        `chk(e, 1'h1)
        apb(1, 20'h10180, 0);
        `chk(e, 1'h1)
        repeat (4) begin
            r = $urandom;
            apb(1, 20'h10164, r);
            apb(0, 20'h10164, 0);
            `chk(q, r & 32'hE37F)
            apb(1, 20'h10168, r);
            apb(0, 20'h10168, 0);
            `chk(q, r & 32'h187F)
        end
        // every source against every pin pair; at 4 MHz software keeps codes at or below 48h
        for (int k = 0; k < 16; k++) begin
            sm = $urandom_range(1);
            vv = sm ? $urandom_range(72) : $urandom_range(127);
            nv <= 7'(sm ? $urandom_range(72) : $urandom_range(127));
            nm <= 2'($urandom);
            sw4 <= 1'(sm);
            pa <= k[0];
            pb <= k[1];
            apb(1, 20'h10168, (k[3:2] << 11) | vv);
            sc = k[3:2] == 1 || (k[3:2] == 2 && k[0]) || (k[3:2] == 3 && k[1]);
            outs(1, 0, sc, sc ? vv : nv, nm);
        end
        apb(1, 20'h10168, 0);
        sw4 <= 1'h0;
        // every slot code, with and without hardware enable, down slots 5 to 1
        for (int k = 0; k < 16; k++) begin
            hw_en <= k[3];
            vv = $urandom_range(127);
            sm = $urandom_range(3);
            apb(1, 20'h10164, (k[2:0] << 13) | (sm << 8) | vv);
            act = k[2:0] == 0 ? 5 : k[2:0] == 6 ? 3 : k[2:0] == 7 ? 1 : 6 - k[2:0];
            dis = k[2:0] inside {[1:5]} && !k[3];
            slp_req <= 1'h1;
            for (int t = 5; t >= 1; t--) begin
                @(posedge pclk);
                ts <= 3'(t);
                strobe <= 1'h1;
                @(posedge pclk);
                strobe <= 1'h0;
                sc = !dis && t <= act;
                outs(!(dis && t <= act), sc, 0, sc ? vv : nv, sc ? sm : nm);
            end
            apb(0, 20'h10180, 0);
            `chk(q, {21'h0, 7'(dis ? nv : vv), 2'h0, dis, !dis})
            slp_req <= 1'h0;
            outs(1, 0, 0, nv, nm);
        end
        report_and_stop();
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
